// file: rcd_pkg.sv
// rcd_pkg: constants and types of the receive clock distribution block
// -----------------------------------------------------------------
// -----------------------------------------------------------------
`default_nettype none
package rcd_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RST  = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_PAR  = 8'h0c;
	localparam logic [7:0] REG_FAB  = 8'h10;
	localparam logic [7:0] REG_OVR  = 8'h14;
	// control, reset and status fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int MODE_W        = 4;
	localparam int DEC_EN_BIT    = 4;
	localparam int BORD_EN_BIT   = 5;
	localparam int HIP_EN_BIT    = 6;
	localparam int BDS_REQ_BIT   = 7;
	localparam int RST_DIG_LSB   = 16;
	localparam int STAT_RM_BIT   = 0;
	localparam int STAT_BDS_BIT  = 1;
	// reset values
	localparam logic [31:0] CTRL_INIT = 32'h0000_0010;
	localparam logic [31:0] RST_INIT  = 32'h0000_0000;
	// parallel clock figures in kHz
	localparam logic [19:0] KHZ_NONE  = 20'h00000;
	localparam logic [19:0] KHZ_SRIO  = 20'h4c4b4; // 312500
	localparam logic [19:0] KHZ_SONET = 20'h12fb6; // 77750
	localparam logic [19:0] KHZ_PCIE2 = 20'h7a120; // 500000
	localparam logic [19:0] KHZ_PCIE1 = 20'h3d090; // 250000
	localparam logic [19:0] KHZ_GBE   = 20'h1e848; // 125000
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		M_SRIO, M_SONET, M_SDI, M_CPRI, M_BASIC,
		M_PCIE_G1, M_PCIE_G2, M_GBE, M_SRIO_RM, M_BASIC_RM
	} rcd_mode_t;

	// per-channel clock enables handed to the pcs sub-blocks
	typedef struct packed {
		logic wa;
		logic dec;
		logic rmf_wr;
		logic rmf_rd;
		logic bds_wr;
		logic bds_rd;
		logic bord;
		logic pcf_wr;
		logic fab;
		logic fab_tx;
	} rcd_ce_t;
endpackage
`default_nettype wire

// file: rcd_top.sv
// rcd_top: receive clock distribution for non-bonded channels
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rcd_top #(
	parameter int NUM_CH = 2,
	parameter int WORD_W = 10
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       clk_en,
	input  wire logic [7:0]                 awaddr,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [7:0]                 araddr,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	input  wire logic [NUM_CH-1:0]          cdr_tick,
	input  wire logic [2*NUM_CH-1:0]        cdr_bits,
	input  wire logic [NUM_CH-1:0]          txdiv_tick,
	output rcd_pkg::rcd_ce_t [NUM_CH-1:0]   ce_out,
	output logic [NUM_CH-1:0]               fab_valid,
	output logic [2*NUM_CH*WORD_W-1:0]      fab_data,
	input  wire logic [NUM_CH-1:0]          fab_ready
);
	localparam int SER_DIV = WORD_W / 2; // two bits per serial edge pair
	localparam int CW      = $clog2(SER_DIV);
	localparam int DW      = 2 * WORD_W;

	// -----------------------------------------------------------
	// register bus
	// -----------------------------------------------------------
	logic [31:0] ctrl, next_ctrl, rst, next_rst;
	logic [31:0] ovr, next_ovr, ovr_set;
	logic        aw_ok, next_aw_ok, w_ok, next_w_ok;
	logic [7:0]  aw_a, next_aw_a;
	logic [31:0] w_d, next_w_d, wmask;
	logic [3:0]  w_s, next_w_s;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        rm, eff_bds;
	logic [19:0] par_khz, fab_khz;
	rcd_pkg::rcd_mode_t mode;

	assign awready = !aw_ok && !bvalid;
	assign wready  = !w_ok && !bvalid;
	assign arready = !rvalid;

	// mode decode: clocking scheme and fixed clock figures
	always_comb
	begin
		mode    = rcd_pkg::rcd_mode_t'(ctrl[rcd_pkg::CTRL_MODE_LSB +: rcd_pkg::MODE_W]);
		rm      = 1'b0;
		eff_bds = ctrl[rcd_pkg::BDS_REQ_BIT];
		par_khz = rcd_pkg::KHZ_NONE;
		case (mode)
			rcd_pkg::M_SRIO: // 3.125 Gbps rate assumed
			begin
				eff_bds = 1'b1;
				par_khz = rcd_pkg::KHZ_SRIO;
			end
			rcd_pkg::M_SONET:
			begin
				eff_bds = 1'b0;
				par_khz = rcd_pkg::KHZ_SONET;
			end
			rcd_pkg::M_SDI, rcd_pkg::M_CPRI, rcd_pkg::M_BASIC:
				rm = 1'b0;
			rcd_pkg::M_PCIE_G1:
			begin
				rm      = 1'b1;
				eff_bds = !ctrl[rcd_pkg::HIP_EN_BIT];
				par_khz = rcd_pkg::KHZ_PCIE1;
			end
			rcd_pkg::M_PCIE_G2:
			begin
				rm      = 1'b1;
				eff_bds = 1'b1;
				par_khz = rcd_pkg::KHZ_PCIE2;
			end
			rcd_pkg::M_GBE:
			begin
				rm      = 1'b1;
				eff_bds = 1'b0;
				par_khz = rcd_pkg::KHZ_GBE;
			end
			rcd_pkg::M_SRIO_RM, rcd_pkg::M_BASIC_RM:
				rm = 1'b1;
			default:
				rm = 1'b0;
		endcase
		fab_khz = eff_bds ? {1'b0, par_khz[19:1]} : par_khz;
	end

	// write/read decode; writes land once address and data are both held
	always_comb
	begin
		next_aw_ok  = aw_ok;
		next_aw_a   = aw_a;
		next_w_ok   = w_ok;
		next_w_d    = w_d;
		next_w_s    = w_s;
		next_bvalid = bvalid;
		next_bresp  = bresp;
		next_rvalid = rvalid;
		next_rresp  = rresp;
		next_rdata  = rdata;
		next_ctrl   = ctrl;
		next_rst    = rst;
		wmask       = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};
		next_ovr    = ovr;
		if (awvalid && awready)
		begin
			next_aw_ok = 1'b1;
			next_aw_a  = awaddr;
		end
		if (wvalid && wready)
		begin
			next_w_ok = 1'b1;
			next_w_d  = wdata;
			next_w_s  = wstrb;
		end
		if (bvalid && bready)
			next_bvalid = 1'b0;
		if (aw_ok && w_ok && !bvalid)
		begin
			next_aw_ok  = 1'b0;
			next_w_ok   = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = rcd_pkg::RESP_OKAY;
			case (aw_a)
				rcd_pkg::REG_CTRL: next_ctrl = (ctrl & ~wmask) | (w_d & wmask);
				rcd_pkg::REG_RST:  next_rst  = (rst & ~wmask) | (w_d & wmask);
				rcd_pkg::REG_OVR:  next_ovr  = ovr & ~(w_d & wmask);
				rcd_pkg::REG_STAT, rcd_pkg::REG_PAR, rcd_pkg::REG_FAB:
					next_bresp = rcd_pkg::RESP_OKAY; // read-only, write ignored
				default: next_bresp = rcd_pkg::RESP_SLVERR;
			endcase
		end
		next_ovr = next_ovr | ovr_set; // set wins over clear
		if (rvalid && rready)
			next_rvalid = 1'b0;
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = rcd_pkg::RESP_OKAY;
			case (araddr)
				rcd_pkg::REG_CTRL: next_rdata = ctrl;
				rcd_pkg::REG_RST:  next_rdata = rst;
				rcd_pkg::REG_STAT:
				begin
					next_rdata = 32'h0000_0000;
					next_rdata[rcd_pkg::STAT_RM_BIT]  = rm;
					next_rdata[rcd_pkg::STAT_BDS_BIT] = eff_bds;
				end
				rcd_pkg::REG_PAR:  next_rdata = 32'(par_khz);
				rcd_pkg::REG_FAB:  next_rdata = 32'(fab_khz);
				rcd_pkg::REG_OVR:  next_rdata = ovr;
				default:
				begin
					next_rdata = 32'h0000_0000;
					next_rresp = rcd_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// bus registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_ok  <= 1'b0;
			aw_a   <= 8'h00;
			w_ok   <= 1'b0;
			w_d    <= 32'h0000_0000;
			w_s    <= 4'h0;
			bvalid <= 1'b0;
			bresp  <= rcd_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rresp  <= rcd_pkg::RESP_OKAY;
			rdata  <= 32'h0000_0000;
			ctrl   <= rcd_pkg::CTRL_INIT;
			rst    <= rcd_pkg::RST_INIT;
			ovr    <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			aw_ok  <= next_aw_ok;
			aw_a   <= next_aw_a;
			w_ok   <= next_w_ok;
			w_d    <= next_w_d;
			w_s    <= next_w_s;
			bvalid <= next_bvalid;
			bresp  <= next_bresp;
			rvalid <= next_rvalid;
			rresp  <= next_rresp;
			rdata  <= next_rdata;
			ctrl   <= next_ctrl;
			rst    <= next_rst;
			ovr    <= next_ovr;
		end
	end

	// -----------------------------------------------------------
	// per-channel clocking and phase compensation buffer
	// -----------------------------------------------------------
	for (genvar g = 0; g < 32; g++)
	begin : g_ovr
		if (g >= NUM_CH)
		begin : g_pad
			assign ovr_set[g] = 1'b0;
		end
	end

	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_ch
		logic          ana, dig, ser, par, tx, src, half, pcw, wr, pop;
		logic [CW-1:0] sc, next_sc;
		logic [WORD_W-1:0] sh, next_sh, pw, next_pw, lo, next_lo, cur;
		logic          ph, next_ph;
		logic [DW-1:0] b0, next_b0, b1, next_b1, din;
		logic [1:0]    cnt, next_cnt;

		// every enable here comes from this channel's own ticks only
		always_comb
		begin
			ana  = rst[g];
			dig  = rst[rcd_pkg::RST_DIG_LSB + g];
			ser  = cdr_tick[g] && !ana;
			par  = ser && (sc == CW'(SER_DIV - 1));
			tx   = txdiv_tick[g] && !dig;
			src  = rm ? tx : (par && !dig);
			half = src && ph;
			pcw  = eff_bds ? half : src;
			cur  = par ? {sh[WORD_W-3:0], cdr_bits[2*g +: 2]} : pw;
			din  = eff_bds ? {cur, lo} : {{WORD_W{1'b0}}, cur};
			pop  = fab_valid[g] && fab_ready[g];
			wr   = pcw && (cnt != 2'h2 || pop);
			// deserializer on the serial clock, two bits per edge pair
			next_sc = sc;
			next_sh = sh;
			next_pw = cur; // fresh word is taken on the parallel tick
			if (ana)
			begin
				next_sc = '0;
				next_sh = '0;
			end
			else if (ser)
			begin
				next_sh = {sh[WORD_W-3:0], cdr_bits[2*g +: 2]};
				next_sc = par ? '0 : sc + CW'(1);
			end
			// divide-by-two phase and byte pairing
			next_ph  = ph;
			next_lo  = lo;
			next_b0  = b0;
			next_b1  = b1;
			next_cnt = cnt;
			if (src)
				next_ph = !ph;
			if (src && !ph)
				next_lo = cur;
			if (pop)
			begin
				next_b0  = b1;
				next_cnt = cnt - 2'h1;
			end
			if (wr)
			begin
				if (next_cnt == 2'h0)
					next_b0 = din;
				else
					next_b1 = din;
				next_cnt = next_cnt + 2'h1;
			end
			if (dig)
			begin
				next_ph  = 1'b0;
				next_lo  = '0;
				next_cnt = 2'h0;
			end
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				sc  <= '0;
				sh  <= '0;
				pw  <= '0;
				lo  <= '0;
				ph  <= 1'b0;
				b0  <= '0;
				b1  <= '0;
				cnt <= 2'h0;
			end
			else if (clk_en)
			begin
				sc  <= next_sc;
				sh  <= next_sh;
				pw  <= next_pw;
				lo  <= next_lo;
				ph  <= next_ph;
				b0  <= next_b0;
				b1  <= next_b1;
				cnt <= next_cnt;
			end
		end

		// enables for the pcs sub-blocks of this channel
		assign ce_out[g].wa     = par && !dig;
		assign ce_out[g].dec    = ctrl[rcd_pkg::DEC_EN_BIT] && (rm ? tx : (par && !dig));
		assign ce_out[g].rmf_wr = rm && par && !dig;
		assign ce_out[g].rmf_rd = rm && tx;
		assign ce_out[g].bds_wr = eff_bds && src;
		assign ce_out[g].bds_rd = eff_bds && half;
		assign ce_out[g].bord   = eff_bds && ctrl[rcd_pkg::BORD_EN_BIT] && half;
		assign ce_out[g].pcf_wr = pcw;
		assign ce_out[g].fab    = pcw;
		assign ce_out[g].fab_tx = rm;
		assign fab_valid[g]     = cnt != 2'h0;
		assign ovr_set[g]       = pcw && !wr; // receiver stalled too long
		assign fab_data[g*DW +: DW] = b0;
	end
endmodule // rcd_top
`default_nettype wire

// file: rcd_monitor.sv
// rcd_monitor: port checker for the receive clock distribution block
`timescale 1ns/1ps
`default_nettype none
module rcd_monitor #(
	parameter int NUM_CH = 2,
	parameter int WORD_W = 10
) (
	input wire logic                     aclk,
	input wire logic                     aresetn,
	input wire logic                     awvalid,
	input wire logic                     awready,
	input wire logic                     wvalid,
	input wire logic                     wready,
	input wire logic                     bvalid,
	input wire logic                     arvalid,
	input wire logic                     arready,
	input wire logic [31:0]              rdata,
	input wire logic                     rvalid,
	input wire logic                     rready,
	input wire logic [NUM_CH-1:0]        cdr_tick,
	input wire logic [NUM_CH-1:0]        txdiv_tick,
	input wire rcd_pkg::rcd_ce_t [NUM_CH-1:0] ce_out,
	input wire logic [NUM_CH-1:0]        fab_valid,
	input wire logic [2*NUM_CH*WORD_W-1:0] fab_data,
	input wire logic [NUM_CH-1:0]        fab_ready
);
	// ----------------------------------------
	// checks on channel 0 and the register bus
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	rcd_pkg::rcd_ce_t c;
	assign c = ce_out[0];
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	a_write_resp: assert property (s_wr_taken |-> ##2 bvalid)
		else $error("write answer late");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data moved");
	a_pcf_fab: assert property ((c.pcf_wr == c.fab)
		&& (!c.pcf_wr || (c.fab_tx ? txdiv_tick[0] : c.wa)))
		else $error("fifo write and fabric tick differ");
	a_par_from_cdr: assert property (c.wa |-> cdr_tick[0])
		else $error("aligner tick without serial tick");
	a_rm_write: assert property (c.fab_tx |-> c.rmf_wr == c.wa)
		else $error("matcher write not on parallel tick");
	a_rm_read: assert property (c.rmf_rd |-> c.fab_tx && txdiv_tick[0])
		else $error("matcher read not on divider tick");
	a_no_rm_fifo: assert property (!c.fab_tx |-> !c.rmf_wr && !c.rmf_rd)
		else $error("matcher clocked without matcher");
	a_dec_par: assert property (!c.fab_tx && c.dec |-> c.wa)
		else $error("decoder off parallel tick");
	a_fab_half: assert property (!c.fab_tx && c.fab |-> c.wa)
		else $error("fabric tick off parallel tick");
	a_bds_read: assert property (!c.fab_tx && c.bds_rd |-> c.fab)
		else $error("byte read off fabric tick");
	a_fab_hold: assert property (fab_valid[0] && !fab_ready[0]
		|=> fab_valid[0] && $stable(fab_data[2*WORD_W-1:0]))
		else $error("fabric word moved while stalled");
endmodule // rcd_monitor

bind rcd_top rcd_monitor #(.NUM_CH(NUM_CH), .WORD_W(WORD_W)) u_mon (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid,
	.arready, .rdata, .rvalid, .rready, .cdr_tick, .txdiv_tick, .ce_out,
	.fab_valid, .fab_data, .fab_ready
);
`default_nettype wire

// file: rcd_fabric_model.sv
// rcd_fabric_model: fabric logic latching one channel's receive words
`timescale 1ns/1ps
`default_nettype none
module rcd_fabric_model #(
	parameter int W = 20
) (
	input wire logic         aclk,
	input wire logic         aresetn,
	input wire logic         valid,
	input wire logic [W-1:0] data,
	input wire logic         stall,
	output logic             ready
);
	// -----------------------
	// capture on handshake
	// -----------------------
	logic [W-1:0] got[$];
	// ready may drop any cycle; a real fabric stalls too
	always @(posedge aclk)
	begin
		ready <= aresetn && !stall;
		if (aresetn && valid && ready)
			got.push_back(data);
	end
endmodule // rcd_fabric_model
`default_nettype wire

// file: rx_nonbonded_clock_distribution_tb_top.sv
// rx_nonbonded_clock_distribution_tb_top: self-checking bench for rcd_top
`timescale 1ns/1ps
`default_nettype none
module rx_nonbonded_clock_distribution_tb_top;
	// -----------------------
	// signals and instances
	// -----------------------
	localparam int NC = 2;
	localparam int WW = 10;
	logic aclk, aresetn, clk_en, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, hold, half;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, seed, rnd;
	logic [31:0] cyc = 32'h0;
	logic [3:0]  wstrb, cdr_bits;
	logic [1:0]  bresp, rresp, cdr_tick, txdiv_tick, fab_valid, fab_ready, stall;
	rcd_pkg::rcd_ce_t [NC-1:0] ce_out;
	logic [2*NC*WW-1:0] fab_data;
	logic [2*WW-1:0]    exp_q[$], exp1_q[$];
	logic [WW-1:0]      first;
	int err_total, total_checks;
	rcd_top #(.NUM_CH(NC), .WORD_W(WW)) dut (.aclk, .aresetn, .clk_en, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cdr_tick, .cdr_bits,
		.txdiv_tick, .ce_out, .fab_valid, .fab_data, .fab_ready);
	rcd_fabric_model #(.W(2*WW)) p0 (.aclk, .aresetn, .valid(fab_valid[0]),
		.data(fab_data[2*WW-1:0]), .stall(stall[0] | hold), .ready(fab_ready[0]));
	rcd_fabric_model #(.W(2*WW)) p1 (.aclk, .aresetn, .valid(fab_valid[1]),
		.data(fab_data[4*WW-1:2*WW]), .stall(stall[1]), .ready(fab_ready[1]));
	// clock
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic report_and_stop();
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// bus master: hold each channel until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), (a > 8'h14 || a[1:0] != 2'h0) ? 32'h2 : 32'h0);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		chk(rdata, e);
		chk(32'(rresp), 32'(re));
	endtask
	// expected status and clock figures per mode
	function automatic void expm(input int m, input bit hc, output logic [31:0] p, f, s);
		p = 32'h0;
		f = 32'h0;
		s = {31'h0, m > 4};
		case (m)
			0: begin p = 32'h4c4b4; f = 32'h2625a; s[1] = 1'b1; end
			1: begin p = 32'h12fb6; f = 32'h12fb6; end
			5: begin p = 32'h3d090; f = hc ? 32'h3d090 : 32'h1e848; s[1] = !hc; end
			6: begin p = 32'h7a120; f = 32'h3d090; s[1] = 1'b1; end
			7: begin p = 32'h1e848; f = 32'h1e848; end
			default: ;
		endcase
	endfunction
	// one word of serial ticks, older bit first; channel 1 gets the inverse
	task automatic word(input bit bds, input bit keep);
		logic [31:0]   r;
		logic [WW-1:0] w;
		r = xs();
		w = r[WW-1:0];
		for (int i = WW - 2; i >= 0; i -= 2)
		begin
			@(posedge aclk);
			cdr_tick <= 2'b11;
			cdr_bits <= {~w[i+1 -: 2], w[i+1 -: 2]};
			@(posedge aclk);
			cdr_tick <= 2'b00;
		end
		if (bds && half)
		begin
			exp_q.push_back({w, first});
			exp1_q.push_back(~{w, first});
		end
		else if (!bds)
		begin
			if (keep) exp_q.push_back({{WW{1'b0}}, w});
			if (keep || hold) exp1_q.push_back({{WW{1'b0}}, ~w});
		end
		if (bds) first = w;
		half = bds && !half;
	endtask
	// both channels: channel 1 is never stalled by hold
	task automatic drain();
		repeat (40) @(posedge aclk);
		chk(32'(p0.got.size()), 32'(exp_q.size()));
		chk(32'(p1.got.size()), 32'(exp1_q.size()));
		foreach (exp_q[i])
			if (i < p0.got.size()) chk(32'(p0.got[i]), 32'(exp_q[i]));
		foreach (exp1_q[i])
			if (i < p1.got.size()) chk(32'(p1.got[i]), 32'(exp1_q[i]));
		exp_q.delete();
		exp1_q.delete();
		p0.got.delete();
		p1.got.delete();
	endtask
	// random divider ticks, fabric stalls and the timeout
	always @(posedge aclk)
	begin
		rnd = xs();
		txdiv_tick <= rnd[1:0];
		stall <= rnd[3:2];
		cyc <= cyc + 32'h1;
		if (cyc == 32'h4e20)
		begin
			err_total++;
			report_and_stop();
		end
	end
	// main sequence
	initial
	begin
		int m;
		logic [31:0] p, f, s;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, hold, half} = 8'h0;
		{awaddr, araddr, wdata, cdr_tick, cdr_bits} = 54'h0;
		clk_en = 1'b1;
		wstrb = 4'hf;
		seed = 32'h5a223441;
		err_total = 0;
		total_checks = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(8'h00, 32'h10, 2'h0);
		rdc(8'h3c, 32'h0, 2'h2);
		wr(8'h3c, 32'hffff_ffff);
		for (int k = 0; k < 11; k++)
		begin
			m = (k == 10) ? 5 : k;
			expm(m, k != 10, p, f, s);
			wr(8'h00, 32'h10 | (k != 10 ? 32'h40 : 32'h0) | 32'(m));
			rdc(8'h08, s, 2'h0);
			rdc(8'h0c, p, 2'h0);
			rdc(8'h10, f, 2'h0);
		end
		// rate matched traffic, ports watched by the checker only
		wr(8'h00, 32'h17);
		repeat (3) word(1'b0, 1'b0);
		// plain words on the parallel tick, once matched words are flushed
		wr(8'h00, 32'h11);
		repeat (40) @(posedge aclk);
		p0.got.delete();
		p1.got.delete();
		repeat (4) word(1'b0, 1'b1);
		drain();
		// paired words; digital reset aligns the pair phase
		wr(8'h00, 32'h10);
		wr(8'h04, 32'h30000);
		wr(8'h04, 32'h0);
		repeat (4) word(1'b1, 1'b1);
		drain();
		// stalled fabric: the third word is lost and flagged
		wr(8'h00, 32'h11);
		wr(8'h14, 32'h3);
		hold <= 1'b1;
		for (int i = 0; i < 3; i++) word(1'b0, i < 2);
		rdc(8'h14, 32'h1, 2'h0);
		wr(8'h14, 32'h1);
		rdc(8'h14, 32'h0, 2'h0);
		hold <= 1'b0;
		drain();
		report_and_stop();
	end
endmodule // rx_nonbonded_clock_distribution_tb_top
`default_nettype wire
